// >>> core/cssel_pkg.sv
/*
  Constants for the control signal source selector: selection codes,
  source vector layout, register map and field layout.
  Assumes a single 50 MHz system clock and classic Wishbone register access.
*/
// Behaviour
// - 170: heat-sink or inside temperature warning
// - 175-177: mirror digital, relay, bidir outputs
// - 181: mirror multifunction output digital source
// - 178: actual percentage reached reference percentage
// - 179: mains failed and power regulation active
// - 180: motor circuit breaker function triggered
// - 215: application warning mask critical
// - 264: DC-link service expired, mode alarm
// - 265: fan service expired, mode alarm
// - 270-277: inverted copies of 70-77
// - 284/285: inverted safe-enable inputs
// - 292/293: plain safe-enable inputs
// - 323: mains present and pre-charge done
// - 471: energy saving mode on and switched
// - 6 gives one, 7 gives zero
// - 70 enable, 71-77 inputs, remote override
package cssel_pkg;

  // ==========================================================
  // Selection codes
  localparam int unsigned CODE_W = 10;
  localparam logic [9:0] CODE_ON        = 10'h006;
  localparam logic [9:0] CODE_OFF       = 10'h007;
  localparam logic [9:0] CODE_IN_FIRST  = 10'h046; // 70
  localparam logic [9:0] CODE_IN_LAST   = 10'h04D; // 77
  localparam logic [9:0] CODE_OVERTEMP  = 10'h0AA; // 170
  localparam logic [9:0] CODE_OUT_ONE   = 10'h0AF; // 175
  localparam logic [9:0] CODE_RELAY     = 10'h0B0; // 176
  localparam logic [9:0] CODE_BIDIR_OUT = 10'h0B1; // 177
  localparam logic [9:0] CODE_PCT_REACH = 10'h0B2; // 178
  localparam logic [9:0] CODE_MAINS_FL  = 10'h0B3; // 179
  localparam logic [9:0] CODE_BREAKER   = 10'h0B4; // 180
  localparam logic [9:0] CODE_MFO       = 10'h0B5; // 181
  localparam logic [9:0] CODE_APPL_MASK = 10'h0D7; // 215
  localparam logic [9:0] CODE_SVC_DC    = 10'h108; // 264
  localparam logic [9:0] CODE_SVC_FAN   = 10'h109; // 265
  localparam logic [9:0] CODE_INV_FIRST = 10'h10E; // 270
  localparam logic [9:0] CODE_INV_LAST  = 10'h115; // 277
  localparam logic [9:0] CODE_SEA_INV   = 10'h11C; // 284
  localparam logic [9:0] CODE_SEB_INV   = 10'h11D; // 285
  localparam logic [9:0] CODE_SEA       = 10'h124; // 292
  localparam logic [9:0] CODE_SEB       = 10'h125; // 293
  localparam logic [9:0] CODE_POWER_ON  = 10'h143; // 323
  localparam logic [9:0] CODE_ENERGY    = 10'h1D7; // 471

  // ==========================================================
  // Source vector layout (bits 0..7 follow codes 70..77)
  localparam int unsigned SRC_W       = 23;
  localparam int unsigned SRC_OVT     = 8;
  localparam int unsigned SRC_OUT1    = 9;
  localparam int unsigned SRC_RELAY   = 10;
  localparam int unsigned SRC_BIDIR   = 11;
  localparam int unsigned SRC_PCT     = 12;
  localparam int unsigned SRC_MAINS   = 13;
  localparam int unsigned SRC_BRK     = 14;
  localparam int unsigned SRC_MFO     = 15;
  localparam int unsigned SRC_APPL    = 16;
  localparam int unsigned SRC_SVC_DC  = 17;
  localparam int unsigned SRC_SVC_FAN = 18;
  localparam int unsigned SRC_SEA     = 19;
  localparam int unsigned SRC_SEB     = 20;
  localparam int unsigned SRC_PWR     = 21;
  localparam int unsigned SRC_ENERGY  = 22;

  // ==========================================================
  // Channels and operating modes
  localparam int unsigned NCH = 4;
  localparam logic [1:0] SVC_MODE_ALARM = 2'h2;
  localparam logic [1:0] ENERGY_MANUAL  = 2'h1;
  localparam logic [1:0] ENERGY_AUTO    = 2'h2;

  // ==========================================================
  // Register map (byte addresses) and fields
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] REG_SEL0   = 8'h00; // SEL1..3 follow at +4
  localparam logic [7:0] REG_CONFIG = 8'h10;
  localparam logic [7:0] REG_OUT    = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_MASK   = 8'h1C;
  localparam int unsigned CFG_DC_LSB  = 0;
  localparam int unsigned CFG_FAN_LSB = 2;
  localparam int unsigned CFG_EN_LSB  = 4;
  localparam logic [9:0] SEL_RESET  = 10'h007; // Constant off
  localparam logic [1:0] MODE_RESET = 2'h0;

endpackage : cssel_pkg

// >>> core/cssel_selector.sv
/*
  One selector channel: picks one source bit by its selection code and
  registers it.
  Assumes the source vector and code are synchronous to clk_i.
*/
`timescale 1ns/1ps
module cssel_selector
  import cssel_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Selection
  input  wire logic [CODE_W-1:0] code_i,
  input  wire logic [SRC_W-1:0]  src_i,
  // Registered control signal
  output logic                   ctrl_o
);

  typedef struct packed {
    logic ctrl;
  } cssel_sel_state_t;

  cssel_sel_state_t state;
  cssel_sel_state_t next_state;

  // ==========================================================
  // Code decode; unknown codes give zero
  function automatic logic pick(input logic [CODE_W-1:0] code,
                                input logic [SRC_W-1:0] src);
    logic r;
    r = 1'b0;
    if (code >= CODE_IN_FIRST && code <= CODE_IN_LAST)
      r = src[3'(code - CODE_IN_FIRST)];
    else if (code >= CODE_INV_FIRST && code <= CODE_INV_LAST)
      r = ~src[3'(code - CODE_INV_FIRST)];
    else
    begin
      case (code)
        CODE_ON:        r = 1'b1;
        CODE_OFF:       r = 1'b0;
        CODE_OVERTEMP:  r = src[SRC_OVT];
        CODE_OUT_ONE:   r = src[SRC_OUT1];
        CODE_RELAY:     r = src[SRC_RELAY];
        CODE_BIDIR_OUT: r = src[SRC_BIDIR];
        CODE_PCT_REACH: r = src[SRC_PCT];
        CODE_MAINS_FL:  r = src[SRC_MAINS];
        CODE_BREAKER:   r = src[SRC_BRK];
        CODE_MFO:       r = src[SRC_MFO];
        CODE_APPL_MASK: r = src[SRC_APPL];
        CODE_SVC_DC:    r = src[SRC_SVC_DC];
        CODE_SVC_FAN:   r = src[SRC_SVC_FAN];
        CODE_SEA_INV:   r = ~src[SRC_SEA];
        CODE_SEB_INV:   r = ~src[SRC_SEB];
        CODE_SEA:       r = src[SRC_SEA];
        CODE_SEB:       r = src[SRC_SEB];
        CODE_POWER_ON:  r = src[SRC_PWR];
        CODE_ENERGY:    r = src[SRC_ENERGY];
        default:        r = 1'b0;
      endcase
    end
    return r;
  endfunction : pick

  // ==========================================================
  // Next state
  always_comb
  begin
    next_state      = state;
    next_state.ctrl = pick(code_i, src_i);
  end

  // One cycle of latency; reset forces low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign ctrl_o = state.ctrl;

endmodule : cssel_selector

// >>> core/cssel_top.sv
/*
  Control signal source selector with a Wishbone register file.
  Holds one selection code per consuming function, forms the source
  vector from monitoring flags and terminal inputs, and raises an
  interrupt on rising edges of the selected control signals.
  Assumes all inputs are synchronous to clk_i; monitoring flags are
  produced elsewhere and arrive as levels.
*/
`timescale 1ns/1ps
module cssel_top
  import cssel_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,

  // Wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,

  // Enable and terminal inputs
  input  wire logic             safe_enable_a_i,
  input  wire logic             safe_enable_b_i,
  input  wire logic             remote_mode_i,
  input  wire logic             remote_enable_i,
  input  wire logic [6:0]       remote_inputs_i,
  input  wire logic             digital_input_one_i,
  input  wire logic             digital_input_two_i,
  input  wire logic             bidir_terminal_input_i,
  input  wire logic             digital_input_four_i,
  input  wire logic             digital_input_five_i,
  input  wire logic             multifunction_input_one_digital_i,
  input  wire logic             multifunction_input_two_digital_i,

  // Output mirrors
  input  wire logic             digital_output_one_i,
  input  wire logic             relay_output_i,
  input  wire logic             bidir_terminal_output_i,
  input  wire logic             multifunction_output_digital_i,

  // Monitoring flags
  input  wire logic             heat_sink_warn_i,
  input  wire logic             inside_temp_warn_i,
  input  wire logic             percent_reached_i,
  input  wire logic             mains_failed_i,
  input  wire logic             power_regulation_active_i,
  input  wire logic             breaker_triggered_i,
  input  wire logic             appl_warn_mask_i,
  input  wire logic             dc_service_expired_i,
  input  wire logic             fan_service_expired_i,
  input  wire logic             mains_present_i,
  input  wire logic             precharge_done_i,
  input  wire logic             energy_switch_on_i,

  // Selected control signals and interrupt
  output logic      [NCH-1:0]   ctrl_o,
  output logic                  irq_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [NCH-1:0][CODE_W-1:0] sel;
    logic [1:0]                 dc_mode;
    logic [1:0]                 fan_mode;
    logic [1:0]                 energy_mode;
    logic [NCH-1:0]             mask;
    logic [NCH-1:0]             status;
    logic [NCH-1:0]             prev_ctrl;
    logic                       ack;
    logic [31:0]                rdata;
  } cssel_state_t;

  cssel_state_t state;
  cssel_state_t next_state;

  logic [SRC_W-1:0] src;
  logic [6:0]       local_inputs;
  logic [NCH-1:0]   ctrl;
  logic             access;
  logic             wr;
  logic             rd;
  logic [NCH-1:0]   rise;

  // ==========================================================
  // Helpers

  // Merge write data into a register by byte lane
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[b*8 +: 8] = wdat[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // Register index of a selection code slot, NCH if none
  function automatic logic [2:0] sel_slot(input logic [ADR_W-1:0] adr);
    logic [2:0] r;
    r = 3'(NCH);
    for (int i = 0; i < NCH; i++)
    begin
      if (adr == REG_SEL0 + ADR_W'(4 * i))
        r = 3'(i);
    end
    return r;
  endfunction : sel_slot

  // Packs configuration fields into a word
  function automatic logic [31:0] cfg_word(input cssel_state_t s);
    logic [31:0] r;
    r = '0;
    r[CFG_DC_LSB  +: 2] = s.dc_mode;
    r[CFG_FAN_LSB +: 2] = s.fan_mode;
    r[CFG_EN_LSB  +: 2] = s.energy_mode;
    return r;
  endfunction : cfg_word

  // ==========================================================
  // Source vector

  // Terminal inputs in code order 71..77
  assign local_inputs = {multifunction_input_two_digital_i,
                         multifunction_input_one_digital_i,
                         digital_input_five_i,
                         digital_input_four_i,
                         bidir_terminal_input_i,
                         digital_input_two_i,
                         digital_input_one_i};

  // Flags combined here so each channel only needs a bit pick
  always_comb
  begin
    src = '0;
    // Remote mode replaces the release and every terminal input
    src[0]   = remote_mode_i ? remote_enable_i
                             : (safe_enable_a_i & safe_enable_b_i);
    src[7:1] = remote_mode_i ? remote_inputs_i : local_inputs;
    src[SRC_OVT]     = heat_sink_warn_i | inside_temp_warn_i;
    src[SRC_OUT1]    = digital_output_one_i;
    src[SRC_RELAY]   = relay_output_i;
    src[SRC_BIDIR]   = bidir_terminal_output_i;
    src[SRC_PCT]     = percent_reached_i;
    src[SRC_MAINS]   = mains_failed_i & power_regulation_active_i;
    src[SRC_BRK]     = breaker_triggered_i;
    src[SRC_MFO]     = multifunction_output_digital_i;
    src[SRC_APPL]    = appl_warn_mask_i;
    // Service warnings only count in alarm-message mode
    src[SRC_SVC_DC]  = dc_service_expired_i
                       & (state.dc_mode == SVC_MODE_ALARM);
    src[SRC_SVC_FAN] = fan_service_expired_i
                       & (state.fan_mode == SVC_MODE_ALARM);
    src[SRC_SEA]     = safe_enable_a_i;
    src[SRC_SEB]     = safe_enable_b_i;
    src[SRC_PWR]     = mains_present_i & precharge_done_i;
    src[SRC_ENERGY]  = energy_switch_on_i
                       & ((state.energy_mode == ENERGY_MANUAL)
                       | (state.energy_mode == ENERGY_AUTO));
  end

  // ==========================================================
  // Selector channels, one code each so functions may share a source
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    cssel_selector u_sel (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .code_i (state.sel[g]),
      .src_i  (src),
      .ctrl_o (ctrl[g])
    );
  end

  // ==========================================================
  // Bus decode

  // Ack is given one cycle after the request is seen
  assign access = wb_cyc_i & wb_stb_i & ~state.ack;
  assign wr     = access & wb_we_i;
  assign rd     = access & ~wb_we_i;

  // Rising edges of the selected signals are the interrupt events
  assign rise = ctrl & ~state.prev_ctrl;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [2:0]  slot;
    logic [31:0] w;
    slot = sel_slot(wb_adr_i);
    w    = '0;
    next_state           = state;
    next_state.ack       = access;
    next_state.prev_ctrl = ctrl;

    // Register writes
    if (wr)
    begin
      if (slot != 3'(NCH))
      begin
        w = merge(32'(state.sel[slot]), wb_dat_i, wb_sel_i);
        next_state.sel[slot] = w[CODE_W-1:0];
      end
      else if (wb_adr_i == REG_CONFIG)
      begin
        w = merge(cfg_word(state), wb_dat_i, wb_sel_i);
        next_state.dc_mode     = w[CFG_DC_LSB  +: 2];
        next_state.fan_mode    = w[CFG_FAN_LSB +: 2];
        next_state.energy_mode = w[CFG_EN_LSB  +: 2];
      end
      else if (wb_adr_i == REG_MASK)
      begin
        w = merge(32'(state.mask), wb_dat_i, wb_sel_i);
        next_state.mask = w[NCH-1:0];
      end
    end

    // Read data captured at the accepting edge
    if (rd)
    begin
      if (slot != 3'(NCH))
        next_state.rdata = 32'(state.sel[slot]);
      else if (wb_adr_i == REG_CONFIG)
        next_state.rdata = cfg_word(state);
      else if (wb_adr_i == REG_OUT)
        next_state.rdata = 32'(ctrl);
      else if (wb_adr_i == REG_STATUS)
        next_state.rdata = 32'(state.status);
      else if (wb_adr_i == REG_MASK)
        next_state.rdata = 32'(state.mask);
      else
        next_state.rdata = '0;
    end

    // Read clears status; a same-cycle event still sets its bit
    if (rd && wb_adr_i == REG_STATUS)
      next_state.status = rise;
    else
      next_state.status = state.status | rise;
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state             <= '0;
      state.sel         <= {NCH{SEL_RESET}};
      state.dc_mode     <= MODE_RESET;
      state.fan_mode    <= MODE_RESET;
      state.energy_mode <= MODE_RESET;
    end
    else
      state <= next_state;
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = state.ack;
  assign wb_dat_o = state.rdata;
  assign ctrl_o   = ctrl;
  assign irq_o    = |(state.status & state.mask);

endmodule : cssel_top

// >>> verif/cssel_checker.sv
/*
  Checker for cssel_top: bus handshake, reset state, channel 0 decode.
  Assumes SEL0 is always written with all byte lanes enabled.
*/
`timescale 1ns/1ps
module cssel_checker
  import cssel_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Bus
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic             wb_ack_o,
  // Sources and results
  input  wire logic             safe_enable_a_i,
  input  wire logic             safe_enable_b_i,
  input  wire logic             remote_mode_i,
  input  wire logic             digital_input_one_i,
  input  wire logic             heat_sink_warn_i,
  input  wire logic             inside_temp_warn_i,
  input  wire logic             mains_present_i,
  input  wire logic             precharge_done_i,
  input  wire logic [NCH-1:0]   ctrl_o,
  input  wire logic             irq_o
);
  // ==========================================================
  // Shadow of SEL0, taken on the same edge as the design
  logic [9:0] sel0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sel0 <= SEL_RESET;
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == REG_SEL0)
      sel0 <= wb_dat_i[9:0];
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_pulse;
    s_req |=> s_pulse;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack is not one pulse");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_reset_quiet;
    $fell(rst_i) |-> !irq_o && ctrl_o == '0 && !wb_ack_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not low");
  property p_const_on;
    sel0 == CODE_ON |=> ctrl_o[0];
  endproperty
  a_const_on: assert property (p_const_on) else $error("code on not high");
  property p_bad_code;
    sel0 == 10'h3FF |=> !ctrl_o[0];
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("unknown code not low");
  property p_sea;
    sel0 == CODE_SEA |=> ctrl_o[0] == $past(safe_enable_a_i);
  endproperty
  a_sea: assert property (p_sea) else $error("enable a copy wrong");
  property p_seb_inv;
    sel0 == CODE_SEB_INV |=> ctrl_o[0] == !$past(safe_enable_b_i);
  endproperty
  a_seb_inv: assert property (p_seb_inv) else $error("enable b inverse wrong");
  property p_overtemp;
    sel0 == CODE_OVERTEMP |=> ctrl_o[0] == ($past(heat_sink_warn_i) || $past(inside_temp_warn_i));
  endproperty
  a_overtemp: assert property (p_overtemp) else $error("overtemp wrong");
  property p_power;
    sel0 == CODE_POWER_ON |=> ctrl_o[0] == ($past(mains_present_i) && $past(precharge_done_i));
  endproperty
  a_power: assert property (p_power) else $error("power on wrong");
  property p_inv_in1;
    sel0 == CODE_INV_FIRST + 10'h001 && !remote_mode_i |=> ctrl_o[0] == !$past(digital_input_one_i);
  endproperty
  a_inv_in1: assert property (p_inv_in1) else $error("inverted input wrong");
endmodule : cssel_checker

bind cssel_top cssel_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_i, .wb_ack_o, .safe_enable_a_i, .safe_enable_b_i, .remote_mode_i, .digital_input_one_i,
  .heat_sink_warn_i, .inside_temp_warn_i, .mains_present_i, .precharge_done_i, .ctrl_o, .irq_o);

// >>> verif/cssel_top_bench.sv
/*
  Self-checking bench for cssel_top: registers, decode table, interrupt.
  Assumes the bench alone drives every input, on the rising clock edge.
*/
`timescale 1ns/1ps
module cssel_top_bench
  import cssel_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, irq, ack;
  logic [7:0]  adr;
  logic [3:0]  sel, ctrl;
  logic [31:0] wdat, rdat, q;
  logic [33:0] iv;
  int          err_count, checks;
  // Selection code slots of channels 1..3 follow SEL0 at a stride of four
  localparam logic [7:0] REG_SEL1 = REG_SEL0 + 8'h04;
  localparam logic [7:0] REG_SEL2 = REG_SEL0 + 8'h08;
  localparam logic [7:0] REG_SEL3 = REG_SEL0 + 8'h0C;

  // ==========================================================
  // Design, all source inputs from one vector
  cssel_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .safe_enable_a_i(iv[0]), .safe_enable_b_i(iv[1]), .remote_mode_i(iv[2]),
    .remote_enable_i(iv[3]), .remote_inputs_i(iv[10:4]), .digital_input_one_i(iv[11]),
    .digital_input_two_i(iv[12]), .bidir_terminal_input_i(iv[13]),
    .digital_input_four_i(iv[14]), .digital_input_five_i(iv[15]),
    .multifunction_input_one_digital_i(iv[16]), .multifunction_input_two_digital_i(iv[17]),
    .digital_output_one_i(iv[18]), .relay_output_i(iv[19]), .bidir_terminal_output_i(iv[20]),
    .multifunction_output_digital_i(iv[21]), .heat_sink_warn_i(iv[22]),
    .inside_temp_warn_i(iv[23]), .percent_reached_i(iv[24]), .mains_failed_i(iv[25]),
    .power_regulation_active_i(iv[26]), .breaker_triggered_i(iv[27]),
    .appl_warn_mask_i(iv[28]), .dc_service_expired_i(iv[29]), .fan_service_expired_i(iv[30]),
    .mains_present_i(iv[31]), .precharge_done_i(iv[32]), .energy_switch_on_i(iv[33]),
    .ctrl_o(ctrl), .irq_o(irq));

  // ==========================================================
  // Tasks
  function automatic logic [33:0] b(input int n);
    b = 34'h1 << n;
  endfunction : b
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle; the wait is bounded so a dead slave ends the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
    begin
      err_count++;
      $display("ERROR ack expected 1 seen none");
      test_done();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 4'hF, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, e, q);
  endtask : rd
  // Set sources, select on channel 0, look two edges later
  task automatic try(input logic [9:0] c, input logic [33:0] v, input logic e);
    @(posedge clk_i);
    iv <= v;
    wr(REG_SEL0, {22'h0, c});
    repeat (2) @(posedge clk_i);
    chk("ctrl0", {31'h0, e}, {31'h0, ctrl[0]});
  endtask : try

  // ==========================================================
  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_i, cyc, stb, we, adr, sel, wdat, iv} = {1'b1, 81'h0};
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd("sel", REG_SEL0 + 8'(4 * i), 32'h00000007);
    rd("config", REG_CONFIG, 32'h0);
    rd("mask", REG_MASK, 32'h0);
    rd("status", REG_STATUS, 32'h0);
    rd("out", REG_OUT, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd("unmapped", 8'h20, 32'h0);
    $display("test reset done");
    // Decode table; CONFIG: dc alarm, fan alarm, energy manual
    wr(REG_CONFIG, 32'h0000001A);
    try(CODE_OVERTEMP, b(22), 1'b1);
    try(CODE_OVERTEMP, b(23), 1'b1);
    try(CODE_OVERTEMP, ~(b(22) | b(23)), 1'b0);
    try(CODE_OUT_ONE, b(18), 1'b1);
    try(CODE_RELAY, b(19), 1'b1);
    try(CODE_RELAY, ~b(19), 1'b0);
    try(CODE_BIDIR_OUT, b(20), 1'b1);
    try(CODE_MFO, b(21), 1'b1);
    try(CODE_MFO, ~b(21), 1'b0);
    try(CODE_PCT_REACH, b(24), 1'b1);
    try(CODE_PCT_REACH, ~b(24), 1'b0);
    try(CODE_MAINS_FL, b(25) | b(26), 1'b1);
    try(CODE_MAINS_FL, b(25), 1'b0);
    try(CODE_MAINS_FL, b(26), 1'b0);
    try(CODE_BREAKER, b(27), 1'b1);
    try(CODE_APPL_MASK, b(28), 1'b1);
    try(CODE_SVC_DC, b(29), 1'b1);
    try(CODE_SVC_FAN, b(30), 1'b1);
    try(CODE_POWER_ON, b(31) | b(32), 1'b1);
    try(CODE_POWER_ON, b(31), 1'b0);
    try(CODE_POWER_ON, b(32), 1'b0);
    try(CODE_ENERGY, b(33), 1'b1);
    try(CODE_ENERGY, ~b(33), 1'b0);
    try(CODE_SEA_INV, b(0), 1'b0);
    try(CODE_SEB_INV, b(0), 1'b1);
    try(CODE_SEA, b(0), 1'b1);
    try(CODE_SEB, b(0), 1'b0);
    try(CODE_ON, '0, 1'b1);
    try(CODE_OFF, '1, 1'b0);
    try(10'h3FF, '1, 1'b0);
    // Modes other than alarm, then energy automatic and off
    wr(REG_CONFIG, 32'h00000025);
    try(CODE_SVC_DC, b(29), 1'b0);
    try(CODE_SVC_FAN, b(30), 1'b0);
    try(CODE_ENERGY, b(33), 1'b1);
    wr(REG_CONFIG, 32'h0);
    try(CODE_ENERGY, b(33), 1'b0);
    $display("test modes done");
    // Enable and terminal inputs, local and remote
    try(CODE_IN_FIRST, b(0) | b(1), 1'b1);
    try(CODE_IN_FIRST, b(0), 1'b0);
    try(CODE_IN_FIRST, b(2) | b(3), 1'b1);
    try(CODE_IN_FIRST, b(0) | b(1) | b(2), 1'b0);
    try(CODE_INV_FIRST, b(1), 1'b1);
    for (int k = 0; k < 7; k++)
    begin
      try(CODE_IN_FIRST + 10'(k + 1), b(11 + k), 1'b1);
      try(CODE_INV_FIRST + 10'(k + 1), b(11 + k), 1'b0);
      try(CODE_IN_FIRST + 10'(k + 1), b(2) | b(4 + k), 1'b1);
      try(CODE_IN_FIRST + 10'(k + 1), b(2) | 34'h3F800, 1'b0);
      try(CODE_INV_FIRST + 10'(k + 1), b(2) | 34'h3F800, 1'b1);
    end
    $display("test inputs done");
    // Channels select independently and may share one source
    try(CODE_SEA, b(0), 1'b1);
    wr(REG_SEL1, {22'h0, CODE_SEA});
    wr(REG_SEL2, {22'h0, CODE_SEB});
    wr(REG_SEL3, {22'h0, CODE_ON});
    repeat (2) @(posedge clk_i);
    rd("out", REG_OUT, 32'h0000000B);
    // Interrupt: flush old events, unmask channel 2, then raise it
    xfer(1'b0, REG_STATUS, 32'h0, 4'hF, q);
    rd("status", REG_STATUS, 32'h0);
    wr(REG_MASK, 32'h00000004);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge clk_i);
    iv <= b(0) | b(1);
    repeat (4) @(posedge clk_i);
    chk("irq", 32'h1, {31'h0, irq});
    rd("status", REG_STATUS, 32'h00000004);
    chk("irq", 32'h0, {31'h0, irq});
    // Lane merge: only byte 1 of SEL3 lands, giving an unknown code
    xfer(1'b1, REG_SEL3, 32'hFFFF01FF, 4'h2, q);
    rd("sel3", REG_SEL3, 32'h00000106);
    rd("out", REG_OUT, 32'h00000007);
    $display("test channels done");
    test_done();
  end
endmodule : cssel_top_bench
